/* logic/panel_interrupt_request_logic.sv */
// Front-panel interrupt request logic: encoder, debounce, switch latch,
// acknowledge clearing and interrupt controller port selects.
// Assumes one 20 MHz clock, synchronous inputs, active-low bus lines.
//
// Overview of operation
// R1 - Encoder gives 3-bit code of lowest-numbered pressed switch.
// R2 - Any pressed switch drives group-active low and enable-out high.
// R3 - Group-active starts 10 ms timer; enable-out arms following 500 ns timer.
// R4 - Latch takes encoder code via ID multiplexer when second timer fires.
// R5 - Idle acknowledge counter holds latch data high, setting addressed bit.
// R6 - Latch outputs wire-ORed with matching active-low bus interrupt lines.
// R7 - System controller puts serviced switch on data bits 3-5, interval 8.
// R8 - During acknowledge the multiplexer routes data bits 3-5 to latch address.
// R9 - During acknowledge the latch data input is driven low.
// R10 - Counter then pulses latch enable, clearing the serviced switch bit.
// R11 - Software must not use call interval 4; wrong bit would clear.
// R12 - Port decoder makes separate local and system controller selects.
// R13 - Reads return status, writes deliver commands; address LSB qualifies.
// R14 - System controller select gated by processor address-drive enable.
// R15 - Internal ports except system controller also enable local buffers.
// R16 - System controller on processor bus; local controller via buffers.
// R17 - Any local controller request raises system interrupt line 7.
// R18 - System controller runs fully nested, line 0 highest priority.
// R19 - Reset clears all latch bits and idles acknowledge counter.
module panel_interrupt_request_logic #(
    parameter int unsigned N               = panel_irq_pkg::SWITCH_COUNT,
    parameter int unsigned DEBOUNCE_CYCLES = panel_irq_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned FIRE_CYCLES     = panel_irq_pkg::FIRE_CYCLES
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] switch_n,
    input  wire logic [N-1:0] bus_irq_n,
    input  wire logic         local_ctl_irq,
    input  wire logic         irq_ack_strobe_n,
    input  wire logic         ack_second_cycle,
    input  wire logic [7:0]   cpu_data,
    input  wire logic [7:0]   port_addr,
    input  wire logic         io_read_n,
    input  wire logic         io_write_n,
    input  wire logic         cpu_addr_drive_enable_n,
    output logic [N-1:0]      sys_irq_req,
    output logic [N-1:0]      switch_latch,
    output logic              local_irq_ctl_select_n,
    output logic              sys_irq_ctl_select_n,
    output logic              local_buffer_enable_n,
    output logic              port_addr_lsb,
    output logic              sys_ctl_on_cpu_bus,
    output logic              ack_counter_phase_b
);
    localparam int unsigned W  = panel_irq_pkg::ID_WIDTH;
    localparam int unsigned DW = $clog2(DEBOUNCE_CYCLES + 1);
    localparam int unsigned FW = $clog2(FIRE_CYCLES + 1);

    // Encoder
    logic [W-1:0] enc_code;
    logic         group_active_out;
    logic         enable_chain_out;

    switch_encoder #(
        .N (N),
        .W (W)
    ) u_encoder (
        .switch_n         (switch_n),
        .code             (enc_code),
        .group_active_out (group_active_out),
        .enable_chain_out (enable_chain_out)
    );

    // Debounce timers
    logic [DW-1:0] debounce_count;
    logic          debounce_run;
    logic [FW-1:0] fire_count;
    logic          fire_run;
    logic          fire_pulse;

    wire logic debounce_done = debounce_run && (debounce_count == DW'(DEBOUNCE_CYCLES - 1));
    wire logic fire_done     = fire_run && (fire_count == FW'(FIRE_CYCLES - 1));

    // Timer restarts only when the switch is released and pressed again
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            debounce_run   <= 1'b0;
            debounce_count <= '0;
        end else if (group_active_out) begin
            debounce_run   <= 1'b0;
            debounce_count <= '0;
        end else if (!debounce_run && debounce_count == '0) begin
            debounce_run   <= 1'b1;                                      // [R3]
        end else if (debounce_run) begin
            debounce_count <= debounce_done ? debounce_count : debounce_count + 1'b1;
            debounce_run   <= !debounce_done;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fire_run   <= 1'b0;
            fire_count <= '0;
            fire_pulse <= 1'b0;
        end else begin
            fire_pulse <= fire_done;
            if (debounce_done && enable_chain_out) begin
                fire_run   <= 1'b1;                                      // [R3]
                fire_count <= '0;
            end else if (fire_done) begin
                fire_run   <= 1'b0;
            end else if (fire_run) begin
                fire_count <= fire_count + 1'b1;
            end
        end
    end

    // Acknowledge counter
    panel_irq_pkg::ack_state_t state;
    panel_irq_pkg::ack_state_t next_state;
    logic ack_strobe_prev;

    wire logic ack_edge = ack_strobe_prev && !irq_ack_strobe_n && ack_second_cycle;

    always_comb begin
        case (state)
            panel_irq_pkg::ACK_IDLE:   next_state = ack_edge ? panel_irq_pkg::ACK_SELECT : panel_irq_pkg::ACK_IDLE;
            panel_irq_pkg::ACK_SELECT: next_state = panel_irq_pkg::ACK_CLEAR;
            panel_irq_pkg::ACK_CLEAR:  next_state = panel_irq_pkg::ACK_IDLE;
            default:                   next_state = panel_irq_pkg::ACK_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state           <= panel_irq_pkg::ACK_IDLE;                  // [R19]
            ack_strobe_prev <= 1'b1;
        end else begin
            state           <= next_state;
            ack_strobe_prev <= irq_ack_strobe_n;
        end
    end

    // ID multiplexer and latch write port
    logic [W-1:0] ack_id;
    wire logic    phase_b = (state != panel_irq_pkg::ACK_IDLE);
    panel_irq_pkg::latch_write_t lw;

    // Serviced number captured while the strobe is low; interval 8 assumed [R7] [R11]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_id <= '0;
        end else if (ack_edge) begin
            ack_id <= cpu_data[panel_irq_pkg::ID_LSB +: W];
        end
    end

    // A set that meets a busy acknowledge counter waits for idle instead of being lost
    logic set_pending;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            set_pending <= 1'b0;
        end else if (fire_pulse && phase_b) begin
            set_pending <= 1'b1;
        end else if (!phase_b) begin
            set_pending <= 1'b0;
        end
    end

    wire logic set_write = (fire_pulse || set_pending) && !phase_b;

    assign lw.addr   = phase_b ? ack_id : enc_code;                     // [R4] [R8]
    assign lw.data   = !phase_b;                                        // [R5] [R9]
    assign lw.enable = (state == panel_irq_pkg::ACK_CLEAR) || set_write; // [R10]

    // Switch latch; a set held back by the clear is written once the counter idles
    logic [N-1:0] latch_bits;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            latch_bits <= panel_irq_pkg::LATCH_RESET[N-1:0];             // [R19]
        end else if (lw.enable) begin
            latch_bits[lw.addr] <= lw.data;                              // [R4] [R10]
        end
    end

    // Request lines; line 7 also carries the local controller [R17]
    logic [N-1:0] next_req;
    generate
        for (genvar i = 0; i < N; i++) begin : g_req
            if (i == panel_irq_pkg::LOCAL_IRQ_LINE) begin : g_local
                assign next_req[i] = latch_bits[i] || !bus_irq_n[i] || local_ctl_irq; // [R6] [R17]
            end else begin : g_plain
                assign next_req[i] = latch_bits[i] || !bus_irq_n[i];     // [R6]
            end
        end
    endgenerate

    // Port decoder
    wire logic io_cycle  = !io_read_n || !io_write_n;                   // [R13]
    wire logic hit_sys   = io_cycle && (port_addr[7:1] == panel_irq_pkg::PORT_SYS_IRQ[7:1]);
    wire logic hit_local = io_cycle && (port_addr[7:1] == panel_irq_pkg::PORT_LOCAL_IRQ[7:1]);
    wire logic hit_int   = io_cycle && ((port_addr & panel_irq_pkg::PORT_LOCAL_MASK) == panel_irq_pkg::PORT_LOCAL_MASK);
    panel_irq_pkg::port_select_t next_sel;

    assign next_sel.sys_irq_ctl_select_n   = !(hit_sys && !cpu_addr_drive_enable_n); // [R12] [R14]
    assign next_sel.local_irq_ctl_select_n = !hit_local;                             // [R12]
    assign next_sel.local_buffer_enable_n  = !(hit_int && !hit_sys);                 // [R15] [R16]
    assign next_sel.port_addr_lsb          = port_addr[0];                           // [R13]

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sys_irq_req            <= '0;
            switch_latch           <= '0;
            local_irq_ctl_select_n <= 1'b1;
            sys_irq_ctl_select_n   <= 1'b1;
            local_buffer_enable_n  <= 1'b1;
            port_addr_lsb          <= 1'b0;
            sys_ctl_on_cpu_bus     <= 1'b0;
            ack_counter_phase_b    <= 1'b0;
        end else begin
            sys_irq_req            <= next_req;
            switch_latch           <= latch_bits;
            local_irq_ctl_select_n <= next_sel.local_irq_ctl_select_n;
            sys_irq_ctl_select_n   <= next_sel.sys_irq_ctl_select_n;
            local_buffer_enable_n  <= next_sel.local_buffer_enable_n;
            port_addr_lsb          <= next_sel.port_addr_lsb;
            sys_ctl_on_cpu_bus     <= !next_sel.sys_irq_ctl_select_n; // [R16]
            ack_counter_phase_b    <= phase_b;                           // [R8]
        end
    end
endmodule : panel_interrupt_request_logic

/* logic/panel_irq_pkg.sv */
// Package for the front-panel interrupt request logic.
// Assumes a single 20 MHz clock; all timing counts derive from it.
package panel_irq_pkg;
    localparam int unsigned CLOCK_HZ        = 20_000_000;
    localparam int unsigned DEBOUNCE_MS     = 10;
    localparam int unsigned FIRE_NS         = 500;
    // Least fire time rounds up to whole cycles; the debounce count has no round-up
    localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_MS * (CLOCK_HZ / 1000) + 0) ;
    localparam int unsigned FIRE_CYCLES     = (FIRE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SWITCH_COUNT    = 8;
    localparam int unsigned ID_WIDTH        = 3;
    localparam int unsigned ID_LSB          = 3;
    localparam int unsigned LOCAL_IRQ_LINE  = 7;
    localparam logic [7:0]  PORT_SYS_IRQ    = 8'hFC;
    localparam logic [7:0]  PORT_LOCAL_IRQ  = 8'hFA;
    localparam logic [7:0]  PORT_LOCAL_MASK = 8'hF0;
    localparam logic [7:0]  LATCH_RESET     = 8'h00;

    typedef enum logic [1:0] {
        ACK_IDLE   = 2'b00,
        ACK_SELECT = 2'b01,
        ACK_CLEAR  = 2'b10
    } ack_state_t;

    typedef struct packed {
        logic [ID_WIDTH-1:0] addr;
        logic                data;
        logic                enable;
    } latch_write_t;

    typedef struct packed {
        logic local_irq_ctl_select_n;
        logic sys_irq_ctl_select_n;
        logic local_buffer_enable_n;
        logic port_addr_lsb;
    } port_select_t;
endpackage : panel_irq_pkg

/* logic/switch_encoder.sv */
// Priority encoder for the front-panel switches.
// Assumes active-low switch inputs, already synchronous to the clock.
module switch_encoder #(
    parameter int unsigned N = panel_irq_pkg::SWITCH_COUNT,
    parameter int unsigned W = panel_irq_pkg::ID_WIDTH
) (
    input  wire logic [N-1:0] switch_n,
    output logic      [W-1:0] code,
    output logic              group_active_out,
    output logic              enable_chain_out
);
    function automatic logic [W-1:0] lowest(input logic [N-1:0] act);
        logic [W-1:0] r;
        r = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (act[i]) begin
                r = W'(i);
            end
        end
        return r;
    endfunction : lowest

    wire logic [N-1:0] active = ~switch_n;
    assign code             = lowest(active);   // [R1]
    assign group_active_out = ~|active;          // [R2]
    assign enable_chain_out = |active;           // [R2]
endmodule : switch_encoder

/* verif/panel_interrupt_request_logic_bench.sv */
// Self-checking bench for the panel interrupt request logic.
// Assumes shortened debounce counts; the partner answers acknowledge cycles.
module panel_interrupt_request_logic_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0]                  addr;
        logic                        rd_n;
        logic                        wr_n;
        logic                        cpu_addr_drive_enable_n_n;
        panel_irq_pkg::port_select_t exp;
    } row_t;
    localparam row_t ROWS [7] = '{'{8'hFC, 1'h0, 1'h1, 1'h0, 4'hA}, '{8'hFD, 1'h1, 1'h0, 1'h0, 4'hB},
        '{8'hFC, 1'h0, 1'h1, 1'h1, 4'hE}, '{8'hFA, 1'h0, 1'h1, 1'h0, 4'h4}, '{8'hFB, 1'h1, 1'h0, 1'h0, 4'h5},
        '{8'hF0, 1'h0, 1'h1, 1'h0, 4'hC}, '{8'hC1, 1'h0, 1'h1, 1'h0, 4'hF}};
    logic       clock = 1'h0, rst_n = 1'h0, rd_n = 1'h1, wr_n = 1'h1, cpu_addr_drive_enable_n_n = 1'h1, local_irq = 1'h0, go = 1'h0;
    logic [7:0] switch_n = 8'hFF, bus_irq_n = 8'hFF, port_addr = 8'h00;
    wire  [7:0] cpu_data, sys_irq_req, switch_latch;
    wire        strobe_n, second, on_cpu_bus, phase_b;
    wire panel_irq_pkg::port_select_t sel;
    int         fail_count = 0, n_tests = 0;
    always #25 clock = ~clock;
    panel_interrupt_request_logic #(.DEBOUNCE_CYCLES(20), .FIRE_CYCLES(10)) panel_interrupt_request_logic_i (
        .clock(clock), .rst_n(rst_n), .switch_n(switch_n), .bus_irq_n(bus_irq_n), .local_ctl_irq(local_irq),
        .irq_ack_strobe_n(strobe_n), .ack_second_cycle(second), .cpu_data(cpu_data), .port_addr(port_addr),
        .io_read_n(rd_n), .io_write_n(wr_n), .cpu_addr_drive_enable_n(cpu_addr_drive_enable_n_n), .sys_irq_req(sys_irq_req),
        .switch_latch(switch_latch), .local_irq_ctl_select_n(sel.local_irq_ctl_select_n),
        .sys_irq_ctl_select_n(sel.sys_irq_ctl_select_n), .local_buffer_enable_n(sel.local_buffer_enable_n),
        .port_addr_lsb(sel.port_addr_lsb), .sys_ctl_on_cpu_bus(on_cpu_bus), .ack_counter_phase_b(phase_b));
    panel_irq_partner panel_irq_partner_i (.clock(clock), .go(go), .sys_irq_req(sys_irq_req),
        .irq_ack_strobe_n(strobe_n), .ack_second_cycle(second), .cpu_data(cpu_data));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk
    // Holds the pattern until the latch changes or hold cycles pass
    task automatic press(input logic [7:0] pat, input int hold);
        logic [7:0] old;
        old = switch_latch;
        @(posedge clock) switch_n <= pat;
        for (int k = 0; k < hold && switch_latch === old; k++) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock) switch_n <= 8'hFF;
        repeat (40) @(posedge clock);
        #1;
    endtask : press
    task automatic ack();
        @(posedge clock) go <= 1'h1;
        @(posedge clock) go <= 1'h0;
        repeat (8) @(posedge clock);
        #1;
    endtask : ack
    task automatic test_done();
        if (fail_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        #(50 * 5000);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'h1;
        foreach (ROWS[i]) begin
            @(posedge clock);
            port_addr <= ROWS[i].addr;
            rd_n      <= ROWS[i].rd_n;
            wr_n      <= ROWS[i].wr_n;
            cpu_addr_drive_enable_n_n    <= ROWS[i].cpu_addr_drive_enable_n_n;
            @(posedge clock);
            #1;
            chk("selects", {4'h0, ROWS[i].exp}, {4'h0, sel});
            chk("cpu bus", {7'h00, !ROWS[i].exp.sys_irq_ctl_select_n}, {7'h00, on_cpu_bus});
        end
        press(8'hF6, 80);
        chk("latch", 8'h01, switch_latch);
        chk("requests", 8'h01, sys_irq_req);
        press(8'hFD, 5);
        chk("latch", 8'h01, switch_latch);
        press(8'hDF, 80);
        chk("latch", 8'h21, switch_latch);
        ack();
        chk("latch", 8'h20, switch_latch);
        ack();
        chk("latch", 8'h00, switch_latch);
        @(posedge clock) bus_irq_n <= 8'hFB;
        local_irq <= 1'h1;
        repeat (3) @(posedge clock);
        #1;
        chk("requests", 8'h84, sys_irq_req);
        @(posedge clock) bus_irq_n <= 8'hFF;
        local_irq <= 1'h0;
        press(8'hBF, 80);
        @(posedge clock) rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        #1;
        chk("latch", 8'h00, switch_latch);
        chk("phase", 8'h00, {7'h00, phase_b});
        @(posedge clock) rst_n <= 1'h1;
        repeat (4) @(posedge clock);
        test_done();
    end
endmodule : panel_interrupt_request_logic_bench

/* verif/panel_irq_monitor.sv */
// Checker for the panel interrupt request logic, bound to its top module.
// Assumes the top's single clock domain and its async active-low reset.
module panel_irq_monitor #(
    parameter int unsigned N               = 8,
    parameter int unsigned DEBOUNCE_CYCLES = 20
) (
    input wire logic         clock,
    input wire logic         rst_n,
    input wire logic [N-1:0] switch_n,
    input wire logic [N-1:0] bus_irq_n,
    input wire logic         local_ctl_irq,
    input wire logic         irq_ack_strobe_n,
    input wire logic         ack_second_cycle,
    input wire logic [7:0]   cpu_data,
    input wire logic [7:0]   port_addr,
    input wire logic         cpu_addr_drive_enable_n,
    input wire logic [N-1:0] sys_irq_req,
    input wire logic [N-1:0] switch_latch,
    input wire logic         local_irq_ctl_select_n,
    input wire logic         sys_irq_ctl_select_n,
    input wire logic         local_buffer_enable_n,
    input wire logic         port_addr_lsb,
    input wire logic         sys_ctl_on_cpu_bus,
    input wire logic         ack_counter_phase_b
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Cycles since a press began; saturates so a long hold cannot wrap
    logic [15:0] since;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) since <= '0;
        else if (&switch_n) since <= '0;
        else if (since != 16'hFFFF) since <= since + 16'h0001;
    end
    AST_SET_DELAY: assert property ((switch_latch & ~$past(switch_latch)) != '0 |-> since >= DEBOUNCE_CYCLES)
        else $error("switch latch set before the debounce time");
    AST_SET_CODE: assert property ((switch_latch & ~$past(switch_latch)) != '0 |->
        (switch_latch & ~$past(switch_latch)) == (~$past(switch_n, 4) & ($past(switch_n, 4) + 1'b1)))
        else $error("latch bit set is not the highest priority switch");
    AST_BUS_OR: assert property ($past(rst_n) |-> &(sys_irq_req | $past(bus_irq_n)))
        else $error("low bus line gives no request");
    AST_LINE7: assert property ($past(rst_n) && $past(local_ctl_irq) |-> sys_irq_req[N-1])
        else $error("local controller request missing on line 7");
    AST_LSB: assert property ($past(rst_n) |-> port_addr_lsb == $past(port_addr[0]))
        else $error("port address lsb not passed on");
    AST_SYS_SEL: assert property (!sys_irq_ctl_select_n |->
        !$past(cpu_addr_drive_enable_n) && $past(port_addr[7:1]) == 7'h7E)
        else $error("system controller select without its port or drive enable");
    AST_LOCAL_SEL: assert property (!local_irq_ctl_select_n |-> $past(port_addr[7:1]) == 7'h7D && sys_irq_ctl_select_n)
        else $error("local controller select on a wrong port");
    AST_BUF: assert property (!local_buffer_enable_n |->
        $past(port_addr[7:4]) == 4'hF && $past(port_addr[7:1]) != 7'h7E)
        else $error("local buffer enabled outside the internal ports");
    AST_CPU_BUS: assert property (sys_ctl_on_cpu_bus == !sys_irq_ctl_select_n)
        else $error("system controller bus path differs from its select");
    AST_ACK_PHASE: assert property ($fell(irq_ack_strobe_n) && ack_second_cycle && !ack_counter_phase_b |->
        ##2 ack_counter_phase_b [*2] ##1 !ack_counter_phase_b)
        else $error("acknowledge counter phase of wrong length");
    AST_ACK_CLEAR: assert property ($fell(irq_ack_strobe_n) && ack_second_cycle && !ack_counter_phase_b |->
        ##4 !switch_latch[$past(cpu_data[5:3], 4)])
        else $error("serviced switch bit not cleared");
    AST_RESET: assert property ($rose(rst_n) |-> switch_latch == '0 && !ack_counter_phase_b)
        else $error("latch or counter not clear after reset");
endmodule : panel_irq_monitor

bind panel_interrupt_request_logic panel_irq_monitor #(.N(N), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) panel_irq_monitor_i (
    .clock(clock), .rst_n(rst_n), .switch_n(switch_n), .bus_irq_n(bus_irq_n), .local_ctl_irq(local_ctl_irq),
    .irq_ack_strobe_n(irq_ack_strobe_n), .ack_second_cycle(ack_second_cycle), .cpu_data(cpu_data),
    .port_addr(port_addr), .cpu_addr_drive_enable_n(cpu_addr_drive_enable_n), .sys_irq_req(sys_irq_req),
    .switch_latch(switch_latch), .local_irq_ctl_select_n(local_irq_ctl_select_n),
    .sys_irq_ctl_select_n(sys_irq_ctl_select_n), .local_buffer_enable_n(local_buffer_enable_n),
    .port_addr_lsb(port_addr_lsb), .sys_ctl_on_cpu_bus(sys_ctl_on_cpu_bus), .ack_counter_phase_b(ack_counter_phase_b));

/* verif/panel_irq_partner.sv */
// Processor side: runs a second acknowledge cycle when asked.
// Assumes a call address interval of 8 and a strobe that idles high.
module panel_irq_partner (
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic [7:0] sys_irq_req,
    output logic            irq_ack_strobe_n,
    output logic            ack_second_cycle,
    output logic [7:0]      cpu_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] num = 3'h0;
    initial begin
        irq_ack_strobe_n = 1'h1;
        ack_second_cycle = 1'h0;
        cpu_data         = 8'h00;
    end
    always @(posedge clock) begin
        if (go) begin
            // Fully nested: the lowest numbered request is served first
            for (int i = 7; i >= 0; i--)
                if (sys_irq_req[i]) num = 3'(i);
            cpu_data         <= {2'h0, num, 3'h0};
            irq_ack_strobe_n <= 1'h0;
            ack_second_cycle <= 1'h1;
            repeat (3) @(posedge clock);
            irq_ack_strobe_n <= 1'h1;
            ack_second_cycle <= 1'h0;
            // A released bus must not keep showing the switch number
            cpu_data         <= ~cpu_data;
        end
    end
endmodule : panel_irq_partner
